// *** src/basic_command_decoder_params.svh ***
// Constant values for the basic command decoder.
`ifndef BASIC_COMMAND_DECODER_PARAMS_SVH
`define BASIC_COMMAND_DECODER_PARAMS_SVH

// Command codes on the packet link.
`define CMD_NOP          8'h00
`define CMD_SOFT_RESET   8'h01
`define CMD_READ_ID      8'h04

// Sixteen-bit command addresses on the serial interface.
`define ADDR_NOP         16'h0000
`define ADDR_SOFT_RESET  16'h0100
`define ADDR_MAKER       16'h0400
`define ADDR_VERSION     16'h0401
`define ADDR_PART        16'h0402

// Packet data type codes.
`define DT_GEN_SW1       6'h13
`define DT_GEN_SW2       6'h23
`define DT_GEN_LW        6'h29
`define DT_GEN_RD1       6'h14
`define DT_GEN_RD2       6'h24
`define DT_DCS_SW0       6'h05
`define DT_DCS_SW1       6'h15
`define DT_DCS_LW        6'h39
`define DT_DCS_RD        6'h06

// Highest maker command page that the link may reach.
`define MAX_MAKER_PAGE   8'h08

// Frames to wait after software reset before sleep-in is reached.
`define SWR_FRAMES       10

// Built-in identity bytes; the values are arbitrary.
`define DEF_MAKER        8'h5A
`define DEF_VERSION      8'h01
`define DEF_PART         8'h3C

`endif

// *** src/cmd_pkg.sv ***
// Types shared by the basic command decoder modules.
package cmd_pkg;

	// Sequencer states, Gray coded along the software reset path.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_BLANK = 3'h1,
		ST_LOAD  = 3'h3,
		ST_WAIT  = 3'h2,
		ST_READ  = 3'h6
	} state_t;

endpackage

// *** src/id_if.sv ***
// Interface between the decoder and its identity byte store.
`timescale 1ns/100ps
interface id_if;
	logic       load;    // One-cycle request to reload identity bytes.
	logic [7:0] maker;   // Current maker_code.
	logic [7:0] version; // Current version_code.
	logic [7:0] part;    // Current part_code.

	modport store (input load, output maker, output version, output part);
	modport user  (output load, input maker, input version, input part);
endinterface

// *** src/id_store.sv ***
// Identity byte store loaded from one-time memory or built-in defaults.
`timescale 1ns/100ps
`include "basic_command_decoder_params.svh"
module id_store (
	input  wire logic       clk_i,        // System clock.
	input  wire logic       rst_i,        // Asynchronous reset, active high.
	input  wire logic       otp_written_i,// One-time memory has been written.
	input  wire logic [7:0] otp_maker_i,  // Programmed maker byte.
	input  wire logic [7:0] otp_version_i,// Programmed version byte.
	input  wire logic [7:0] otp_part_i,   // Programmed part byte.
	id_if.store             ids           // Identity bytes toward the decoder.
);

	logic [7:0] maker_q, maker_d;
	logic [7:0] version_q, version_d;
	logic [7:0] part_q, part_d;

	////////////////////////////////////////////////////////////////////////
	// A load takes programmed bytes when present, else the defaults.
	always_comb begin
		maker_d   = maker_q;
		version_d = version_q;
		part_d    = part_q;
		if (ids.load) begin
			if (otp_written_i) begin
				maker_d   = otp_maker_i;
				version_d = otp_version_i;
				part_d    = otp_part_i;
			end else begin
				maker_d   = `DEF_MAKER;
				version_d = `DEF_VERSION;
				part_d    = `DEF_PART;
			end
		end
	end

	// Reset holds the defaults until the first load after release.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			maker_q   <= `DEF_MAKER;
			version_q <= `DEF_VERSION;
			part_q    <= `DEF_PART;
		end else begin
			maker_q   <= maker_d;
			version_q <= version_d;
			part_q    <= part_d;
		end
	end

	// Stored bytes to the decoder.
	assign ids.maker   = maker_q;
	assign ids.version = version_q;
	assign ids.part    = part_q;

endmodule // id_store

// *** src/basic_command_decoder.sv ***
// Decoder for no-operation, software reset and identity read commands.
`timescale 1ns/100ps
`include "basic_command_decoder_params.svh"
module basic_command_decoder #(
	parameter int SWR_FRAMES = `SWR_FRAMES // Frames of software reset wait.
) (
	input  wire logic       clk_i,          // System clock, 20 MHz.
	input  wire logic       rst_i,          // Asynchronous reset, active high.
	input  wire logic       pkt_valid_i,    // Packet link command strobe.
	input  wire logic [5:0] pkt_type_i,     // Packet data type code.
	input  wire logic [7:0] pkt_cmd_i,      // Packet command code.
	input  wire logic [7:0] page_sel_i,     // Selected command page.
	input  wire logic       ser_valid_i,    // Serial interface access strobe.
	input  wire logic       ser_write_i,    // Serial access is a write.
	input  wire logic [15:0] ser_addr_i,    // Serial command address.
	input  wire logic       rd_ready_i,     // Host takes the current byte.
	input  wire logic       partial_mode_i, // Partial display mode active.
	input  wire logic       sleep_out_busy_i,// Sleep-out sequence running.
	input  wire logic       sleep_exit_i,   // Sleep-out has been commanded.
	input  wire logic       frame_tick_i,   // One pulse per display frame.
	input  wire logic       otp_written_i,  // One-time memory is programmed.
	input  wire logic [7:0] otp_maker_i,    // Programmed maker byte.
	input  wire logic [7:0] otp_version_i,  // Programmed version byte.
	input  wire logic [7:0] otp_part_i,     // Programmed part byte.
	output logic       done_o,              // Command completed pulse.
	output logic       refused_o,           // Command refused pulse.
	output logic       page_fwd_o,          // Maker page packet accepted.
	output logic       busy_o,              // Software reset in progress.
	output logic       blank_o,             // Whole screen blanked.
	output logic       load_defaults_o,     // Reset defaults load pulse.
	output logic       sleep_in_o,          // Sleep-in mode reached.
	output logic [7:0] rd_data_o,           // Read response byte.
	output logic       rd_valid_o,          // Read response byte valid.
	output logic       rd_last_o            // Last byte of the response.
);

	// Parameter check.
	if (SWR_FRAMES < 1 || SWR_FRAMES > 255) begin : g_chk
		$error("SWR_FRAMES must lie in 1 to 255");
	end

	localparam logic [7:0] FRAMES_C = 8'(SWR_FRAMES);

	////////////////////////////////////////////////////////////////////////
	// Type checks on packet data type codes.
	function automatic logic is_write_type(input logic [5:0] t);
		return t == `DT_GEN_SW1 || t == `DT_GEN_SW2 || t == `DT_GEN_LW ||
			t == `DT_DCS_SW0 || t == `DT_DCS_SW1 || t == `DT_DCS_LW;
	endfunction

	function automatic logic is_read_type(input logic [5:0] t);
		return t == `DT_GEN_RD1 || t == `DT_GEN_RD2 || t == `DT_DCS_RD;
	endfunction

	// Packet kinds that may reach a maker command page.
	function automatic logic is_page_type(input logic [5:0] t);
		return t == `DT_GEN_SW1 || t == `DT_GEN_SW2 || t == `DT_GEN_LW ||
			t == `DT_GEN_RD1 || t == `DT_GEN_RD2 || t == `DT_DCS_SW1 ||
			t == `DT_DCS_LW || t == `DT_DCS_RD;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Identity byte store.
	id_if ids ();

	id_store u_id_store (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.otp_written_i (otp_written_i),
		.otp_maker_i   (otp_maker_i),
		.otp_version_i (otp_version_i),
		.otp_part_i    (otp_part_i),
		.ids           (ids)
	);

	cmd_pkg::state_t st_q, st_d;
	logic [7:0] frm_q, frm_d;
	logic [1:0] idx_q, idx_d;
	logic       boot_q, boot_d;
	logic       load_q, load_d;
	logic       done_q, done_d;
	logic       refused_q, refused_d;
	logic       fwd_q, fwd_d;
	logic       blank_q, blank_d;
	logic       dflt_q, dflt_d;
	logic       sleep_q, sleep_d;
	logic [7:0] rdat_q, rdat_d;
	logic       rval_q, rval_d;
	logic       rlast_q, rlast_d;

	// Request decode, packet link first.
	logic       user_page;
	logic       req_nop;
	logic       req_swr;
	logic       req_id3;
	logic       req_id1;
	logic [1:0] req_idx;

	always_comb begin
		user_page = page_sel_i == 8'h00;
		req_nop   = 1'b0;
		req_swr   = 1'b0;
		req_id3   = 1'b0;
		req_id1   = 1'b0;
		req_idx   = 2'h0;
		if (pkt_valid_i) begin
			if (user_page && is_write_type(pkt_type_i)) begin
				req_nop = pkt_cmd_i == `CMD_NOP;
				req_swr = pkt_cmd_i == `CMD_SOFT_RESET;
			end else if (user_page && is_read_type(pkt_type_i)) begin
				req_id3 = pkt_cmd_i == `CMD_READ_ID;
			end
		end else if (ser_valid_i) begin
			if (ser_write_i && ser_addr_i == `ADDR_NOP) begin
				req_nop = 1'b1;
			end else if (ser_write_i && ser_addr_i == `ADDR_SOFT_RESET) begin
				req_swr = 1'b1;
			end else if (!ser_write_i && ser_addr_i == `ADDR_MAKER) begin
				req_id1 = 1'b1;
				req_idx = 2'h0;
			end else if (!ser_write_i && ser_addr_i == `ADDR_VERSION) begin
				req_id1 = 1'b1;
				req_idx = 2'h1;
			end else if (!ser_write_i && ser_addr_i == `ADDR_PART) begin
				req_id1 = 1'b1;
				req_idx = 2'h2;
			end
		end
	end

	// Identity byte selected by index.
	function automatic logic [7:0] id_byte(input logic [1:0] i,
		input logic [7:0] m, input logic [7:0] v, input logic [7:0] p);
		return (i == 2'h0) ? m : (i == 2'h1) ? v : p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state.
	always_comb begin
		st_d      = st_q;
		frm_d     = frm_q;
		idx_d     = idx_q;
		boot_d    = 1'b0;
		load_d    = boot_q;
		done_d    = 1'b0;
		refused_d = 1'b0;
		fwd_d     = 1'b0;
		blank_d   = blank_q;
		dflt_d    = 1'b0;
		sleep_d   = sleep_q;
		rdat_d    = rdat_q;
		rval_d    = rval_q;
		rlast_d   = rlast_q;
		if (sleep_exit_i) begin
			sleep_d = 1'b0;
		end
		// Maker page packets are accepted only for listed kinds.
		if (pkt_valid_i && !(page_sel_i == 8'h00)) begin
			if (page_sel_i <= `MAX_MAKER_PAGE &&
				is_page_type(pkt_type_i) && st_q == cmd_pkg::ST_IDLE) begin
				fwd_d = 1'b1;
			end else begin
				refused_d = 1'b1;
			end
		end
		case (st_q)
			cmd_pkg::ST_IDLE: begin
				if ((req_nop || req_swr || req_id3 || req_id1) &&
					partial_mode_i) begin
					refused_d = 1'b1;
				end else if (req_nop) begin
					done_d = 1'b1;
				end else if (req_swr && sleep_out_busy_i) begin
					refused_d = 1'b1;
				end else if (req_swr) begin
					blank_d = 1'b1;
					st_d    = cmd_pkg::ST_BLANK;
				end else if (req_id3 || req_id1) begin
					idx_d   = req_id3 ? 2'h0 : req_idx;
					rdat_d  = id_byte(idx_d, ids.maker, ids.version,
						ids.part);
					rval_d  = 1'b1;
					rlast_d = req_id1 || idx_d == 2'h2;
					st_d    = cmd_pkg::ST_READ;
				end
			end
			cmd_pkg::ST_BLANK: begin
				dflt_d = 1'b1;
				load_d = 1'b1;
				st_d   = cmd_pkg::ST_LOAD;
			end
			cmd_pkg::ST_LOAD: begin
				frm_d = FRAMES_C;
				st_d  = cmd_pkg::ST_WAIT;
			end
			cmd_pkg::ST_WAIT: begin
				if (frame_tick_i) begin
					frm_d = frm_q - 8'h01;
					if (frm_q == 8'h01) begin
						sleep_d = 1'b1;
						blank_d = 1'b0;
						done_d  = 1'b1;
						st_d    = cmd_pkg::ST_IDLE;
					end
				end
			end
			cmd_pkg::ST_READ: begin
				if (rd_ready_i) begin
					if (rlast_q) begin
						rval_d  = 1'b0;
						rlast_d = 1'b0;
						done_d  = 1'b1;
						st_d    = cmd_pkg::ST_IDLE;
					end else begin
						idx_d   = idx_q + 2'h1;
						rdat_d  = id_byte(idx_d, ids.maker, ids.version,
							ids.part);
						rlast_d = idx_d == 2'h2;
					end
				end
			end
			default: begin
				st_d = cmd_pkg::ST_IDLE;
			end
		endcase
		// Anything else arriving mid-sequence is dropped and flagged.
		if (st_q != cmd_pkg::ST_IDLE &&
			(req_nop || req_swr || req_id3 || req_id1)) begin
			refused_d = 1'b1;
		end
	end

	assign ids.load = load_q;

	// Sequencer registers; boot flag requests the power-on identity load.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q      <= cmd_pkg::ST_IDLE;
			frm_q     <= 8'h00;
			idx_q     <= 2'h0;
			boot_q    <= 1'b1;
			load_q    <= 1'b0;
			done_q    <= 1'b0;
			refused_q <= 1'b0;
			fwd_q     <= 1'b0;
			blank_q   <= 1'b0;
			dflt_q    <= 1'b0;
			sleep_q   <= 1'b1;
			rdat_q    <= 8'h00;
			rval_q    <= 1'b0;
			rlast_q   <= 1'b0;
		end else begin
			st_q      <= st_d;
			frm_q     <= frm_d;
			idx_q     <= idx_d;
			boot_q    <= boot_d;
			load_q    <= load_d;
			done_q    <= done_d;
			refused_q <= refused_d;
			fwd_q     <= fwd_d;
			blank_q   <= blank_d;
			dflt_q    <= dflt_d;
			sleep_q   <= sleep_d;
			rdat_q    <= rdat_d;
			rval_q    <= rval_d;
			rlast_q   <= rlast_d;
		end
	end

	// Outputs straight from flip-flops.
	assign done_o          = done_q;
	assign refused_o       = refused_q;
	assign page_fwd_o      = fwd_q;
	assign busy_o          = blank_q; // Blank spans the whole reset run.
	assign blank_o         = blank_q;
	assign load_defaults_o = dflt_q;
	assign sleep_in_o      = sleep_q;
	assign rd_data_o       = rdat_q;
	assign rd_valid_o      = rval_q;
	assign rd_last_o       = rlast_q;

endmodule // basic_command_decoder

// *** sim/basic_command_decoder_sva.sv ***
// Port assertions for the basic command decoder.
`timescale 1ns/100ps
`include "basic_command_decoder_params.svh"
module basic_command_decoder_chk (
	input wire logic        clk_i,            // Clock.
	input wire logic        rst_i,            // Reset.
	input wire logic        pkt_valid_i,      // Packet strobe.
	input wire logic [5:0]  pkt_type_i,       // Data type.
	input wire logic [7:0]  pkt_cmd_i,        // Command.
	input wire logic [7:0]  page_sel_i,       // Page.
	input wire logic        ser_valid_i,      // Serial strobe.
	input wire logic        ser_write_i,      // Serial write.
	input wire logic [15:0] ser_addr_i,       // Serial address.
	input wire logic        rd_ready_i,       // Byte taken.
	input wire logic        partial_mode_i,   // Partial mode.
	input wire logic        sleep_out_busy_i, // Sleep-out running.
	input wire logic        done_o,           // Done pulse.
	input wire logic        refused_o,        // Refused pulse.
	input wire logic        page_fwd_o,       // Page accepted.
	input wire logic        busy_o,           // Reset running.
	input wire logic        blank_o,          // Screen blank.
	input wire logic        load_defaults_o,  // Defaults pulse.
	input wire logic        sleep_in_o,       // Sleep-in.
	input wire logic [7:0]  rd_data_o,        // Read byte.
	input wire logic        rd_valid_o,       // Byte valid.
	input wire logic        rd_last_o         // Last byte.
);
	logic idle, go, wr_t, rd_t, pg_t;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Idle and usable block, and the packet kinds it may take.
	assign idle = !busy_o && !rd_valid_o && !partial_mode_i;
	assign go = pkt_valid_i && idle && page_sel_i == 8'h00;
	assign wr_t = pkt_type_i inside {`DT_GEN_SW1, `DT_GEN_SW2, `DT_GEN_LW,
		`DT_DCS_SW0, `DT_DCS_SW1, `DT_DCS_LW};
	assign pg_t = pkt_type_i inside {`DT_GEN_SW1, `DT_GEN_SW2, `DT_GEN_LW,
		`DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_SW1, `DT_DCS_LW, `DT_DCS_RD};
	assign rd_t = pkt_type_i inside {`DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_RD};
	// Blank first, then the defaults pulse.
	sequence swr_steps;
		(blank_o && busy_o) ##1 (load_defaults_o && blank_o);
	endsequence
	nop_done_a: assert property (
		go && wr_t && pkt_cmd_i == `CMD_NOP |=> done_o && !blank_o)
		else $error("No-op did not complete.");
	swr_order_a: assert property (
		go && wr_t && pkt_cmd_i == `CMD_SOFT_RESET && !sleep_out_busy_i
		|=> swr_steps) else $error("Reset steps out of order.");
	swr_end_a: assert property (
		$fell(busy_o) |-> done_o && sleep_in_o && !blank_o)
		else $error("Reset did not end in sleep-in.");
	partial_refuse_a: assert property (
		pkt_valid_i && !busy_o && !rd_valid_o && partial_mode_i
		&& page_sel_i == 8'h00 && (wr_t && pkt_cmd_i <= `CMD_SOFT_RESET
		|| rd_t && pkt_cmd_i == `CMD_READ_ID)
		|=> refused_o && !done_o) else $error("Partial mode not refused.");
	id_first_a: assert property (
		go && pkt_cmd_i == `CMD_READ_ID
		&& pkt_type_i inside {`DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_RD}
		|=> rd_valid_o && !rd_last_o) else $error("Identity read bad.");
	ser_byte_a: assert property (
		ser_valid_i && !pkt_valid_i && !ser_write_i && idle
		&& ser_addr_i == `ADDR_VERSION && page_sel_i == 8'h00
		|=> rd_valid_o && rd_last_o) else $error("Serial read bad.");
	byte_hold_a: assert property (
		rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
		else $error("Read byte not held.");
	read_end_a: assert property (
		rd_valid_o && rd_last_o && rd_ready_i |=> !rd_valid_o && done_o)
		else $error("Read did not end after last byte.");
	page_ok_a: assert property (
		pkt_valid_i && idle && pg_t && page_sel_i != 8'h00
		&& page_sel_i <= `MAX_MAKER_PAGE |=> page_fwd_o)
		else $error("Maker page packet not accepted.");
	page_bad_a: assert property (
		pkt_valid_i && idle && page_sel_i > `MAX_MAKER_PAGE |=> refused_o)
		else $error("High page not refused.");
endmodule // basic_command_decoder_chk
bind basic_command_decoder basic_command_decoder_chk
	basic_command_decoder_chk_i (.*);

// *** sim/host_model.sv ***
// Host model that issues commands and takes read bytes.
`timescale 1ns/100ps
module host_model (
	input  wire logic        clk_i,       // Clock.
	input  wire logic        rd_valid_i,  // Byte valid.
	input  wire logic [7:0]  rd_data_i,   // Read byte.
	input  wire logic        rd_last_i,   // Last byte.
	output logic             pkt_valid_o, // Packet strobe.
	output logic [5:0]       pkt_type_o,  // Data type.
	output logic [7:0]       pkt_cmd_o,   // Command.
	output logic             ser_valid_o, // Serial strobe.
	output logic             ser_write_o, // Serial write.
	output logic [15:0]      ser_addr_o,  // Serial address.
	output logic             rd_ready_o,  // Byte taken.
	output logic             frame_tick_o // Frame pulse.
);
	logic [7:0] got [3];     // Bytes taken.
	logic       lst [3];     // Last flags taken.
	logic [2:0] n_q = 3'h0;  // Frame divider.
	// Idle levels from time zero.
	initial begin
		{pkt_valid_o, pkt_type_o, pkt_cmd_o} = '0;
		{ser_valid_o, ser_write_o, ser_addr_o, rd_ready_o} = '0;
	end
	// One frame pulse every eight cycles, changed at the falling edge.
	always @(negedge clk_i) n_q <= n_q + 3'h1;
	assign frame_tick_o = n_q == 3'h0;
	// One request held over one rising edge; returns while the answer stands.
	task automatic send(input logic ser, input logic [5:0] t,
		input logic [7:0] c, input logic wr, input logic [15:0] a);
		@(negedge clk_i);
		pkt_valid_o = !ser;
		ser_valid_o = ser;
		pkt_type_o = t;
		pkt_cmd_o = c;
		ser_write_o = wr;
		ser_addr_o = a;
		@(negedge clk_i);
		pkt_valid_o = 1'b0;
		ser_valid_o = 1'b0;
	endtask
	// Takes n bytes, stalling slow cycles before each.
	task automatic take(input int n, input int slow);
		for (int i = 0; i < n; i++) begin
			for (int w = 0; w < 50 && rd_valid_i !== 1'b1; w++)
				@(negedge clk_i);
			repeat (slow) @(negedge clk_i);
			got[i] = rd_data_i;
			lst[i] = rd_last_i;
			rd_ready_o = 1'b1;
			@(negedge clk_i);
			rd_ready_o = 1'b0;
		end
	endtask
endmodule // host_model

// *** sim/basic_command_decoder_tb.sv ***
// Self-checking bench for the basic command decoder.
`timescale 1ns/100ps
`include "basic_command_decoder_params.svh"
module basic_command_decoder_tb;
	localparam int FRAMES = 4; // Shortened reset wait.
	logic clk_i = 1'b0, rst_i = 1'b1, pkt_valid_i, ser_valid_i, ser_write_i;
	logic partial_mode_i = 1'b0, sleep_out_busy_i = 1'b0;
	logic sleep_exit_i = 1'b0, otp_written_i = 1'b0, rd_ready_i, frame_tick_i;
	logic [7:0] page_sel_i = 8'h00, pkt_cmd_i, rd_data_o;
	logic [7:0] otp_maker_i = 8'hA1, otp_version_i = 8'hB2;
	logic [7:0] otp_part_i = 8'hC3;
	logic [5:0] pkt_type_i;
	logic [15:0] ser_addr_i;
	logic done_o, refused_o, page_fwd_o, busy_o, blank_o, load_defaults_o;
	logic sleep_in_o, rd_valid_o, rd_last_o;
	int err_total = 0, samples_checked = 0;
	logic [5:0] wt [6] = '{`DT_GEN_SW1, `DT_GEN_SW2, `DT_GEN_LW,
		`DT_DCS_SW0, `DT_DCS_SW1, `DT_DCS_LW};
	logic [5:0] pt [8] = '{`DT_GEN_SW1, `DT_GEN_SW2, `DT_GEN_LW,
		`DT_GEN_RD1, `DT_GEN_RD2, `DT_DCS_SW1, `DT_DCS_LW, `DT_DCS_RD};
	logic [7:0] dflt [3] = '{`DEF_MAKER, `DEF_VERSION, `DEF_PART};
	////////////////////////////////////////////////////////////////////
	// Clock and the block with its host.
	always #25 clk_i = ~clk_i;
	basic_command_decoder #(.SWR_FRAMES(FRAMES)) basic_command_decoder_i (
		.clk_i, .rst_i, .pkt_valid_i, .pkt_type_i, .pkt_cmd_i, .page_sel_i,
		.ser_valid_i, .ser_write_i, .ser_addr_i, .rd_ready_i, .partial_mode_i,
		.sleep_out_busy_i, .sleep_exit_i, .frame_tick_i, .otp_written_i,
		.otp_maker_i, .otp_version_i, .otp_part_i, .done_o, .refused_o,
		.page_fwd_o, .busy_o, .blank_o, .load_defaults_o, .sleep_in_o,
		.rd_data_o, .rd_valid_o, .rd_last_o);
	host_model host_model_i (.clk_i, .rd_valid_i(rd_valid_o),
		.rd_data_i(rd_data_o), .rd_last_i(rd_last_o),
		.pkt_valid_o(pkt_valid_i), .pkt_type_o(pkt_type_i),
		.pkt_cmd_o(pkt_cmd_i), .ser_valid_o(ser_valid_i),
		.ser_write_o(ser_write_i), .ser_addr_o(ser_addr_i),
		.rd_ready_o(rd_ready_i), .frame_tick_o(frame_tick_i));
	////////////////////////////////////////////////////////////////////
	// Compares one value and counts the outcome.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Packet identity read of three bytes.
	task automatic rd_id(input logic [5:0] t, input logic [7:0] m, v, p,
		input int slow);
		host_model_i.send(1'b0, t, `CMD_READ_ID, 1'b0, 16'h0000);
		host_model_i.take(3, slow);
		chk(host_model_i.got[0], m);
		chk(host_model_i.got[1], v);
		chk(host_model_i.got[2], p);
		chk(8'({host_model_i.lst[0], host_model_i.lst[1],
			host_model_i.lst[2], done_o}), 8'h03);
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		rd_id(`DT_DCS_RD, `DEF_MAKER, `DEF_VERSION, `DEF_PART, 2);
		for (int a = 0; a < 3; a++) begin
			host_model_i.send(1'b1, 6'h00, 8'h00, 1'b0, `ADDR_MAKER + 16'(a));
			host_model_i.take(1, 0);
			chk(host_model_i.got[0], dflt[a]);
			chk(8'(host_model_i.lst[0]), 8'h01);
		end
		foreach (wt[i]) begin
			host_model_i.send(1'b0, wt[i], `CMD_NOP, 1'b0, 16'h0000);
			chk(8'({done_o, blank_o, refused_o}), 8'h04);
		end
		host_model_i.send(1'b1, 6'h00, 8'h00, 1'b1, `ADDR_NOP);
		chk(8'(done_o), 8'h01);
		partial_mode_i = 1'b1;
		host_model_i.send(1'b0, `DT_DCS_RD, `CMD_READ_ID, 1'b0, 16'h0000);
		chk(8'({rd_valid_o, refused_o}), 8'h01);
		partial_mode_i = 1'b0;
		foreach (pt[i]) begin
			page_sel_i = 8'(i + 1);
			host_model_i.send(1'b0, pt[i], 8'hB0, 1'b0, 16'h0000);
			chk(8'(page_fwd_o), 8'h01);
		end
		page_sel_i = `MAX_MAKER_PAGE + 8'h01;
		host_model_i.send(1'b0, `DT_GEN_LW, 8'hB0, 1'b0, 16'h0000);
		chk(8'({page_fwd_o, refused_o}), 8'h01);
		page_sel_i = 8'h01;
		host_model_i.send(1'b0, `DT_DCS_SW0, 8'hB0, 1'b0, 16'h0000);
		chk(8'({page_fwd_o, refused_o}), 8'h01);
		page_sel_i = 8'h00;
		sleep_exit_i = 1'b1;
		@(negedge clk_i);
		sleep_exit_i = 1'b0;
		chk(8'(sleep_in_o), 8'h00);
		sleep_out_busy_i = 1'b1;
		host_model_i.send(1'b0, `DT_DCS_SW0, `CMD_SOFT_RESET, 1'b0, 16'h0000);
		chk(8'({busy_o, refused_o}), 8'h01);
		sleep_out_busy_i = 1'b0;
		otp_written_i = 1'b1;
		host_model_i.send(1'b0, `DT_GEN_LW, `CMD_SOFT_RESET, 1'b0, 16'h0000);
		chk(8'({blank_o, busy_o, load_defaults_o}), 8'h06);
		@(negedge clk_i);
		chk(8'(load_defaults_o), 8'h01);
		for (int w = 0; w < 40 * FRAMES && done_o !== 1'b1; w++)
			@(negedge clk_i);
		chk(8'({done_o, sleep_in_o, blank_o}), 8'h06);
		rd_id(`DT_GEN_RD1, otp_maker_i, otp_version_i, otp_part_i, 0);
		otp_written_i = 1'b0;
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		rd_id(`DT_GEN_RD2, `DEF_MAKER, `DEF_VERSION, `DEF_PART, 1);
		close_out();
	end
	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		close_out();
	end
endmodule // basic_command_decoder_tb
